// ===== hdl/cdg_seq.sv
`timescale 1ns/1ps
// How it works
// R1: Low wait request during a selected access adds exactly one wait state.
// R2: Outside logic drives combined byte strobe low when either byte strobe is low.
// R3: With hidden refresh disallowed, row strobe only for selected accesses and forced refresh.
// R4: System holds output enable low so registered outputs are driven.
// R5: Cycle done goes low once both delay stages are low after work.
// R6: Cycle done returns high when the address strobe goes high.
// R7: Row strobe asserts after address strobe for access or hidden refresh.
// R8: Acknowledge is withheld to stretch the processor cycle with wait states.
// R9: Access during forced refresh asserts pending output and inserts waits.
// R10: Pending refresh request also blocks an unselected cycle from starting row strobe.
// R11: Forced refresh drives the mode output low, selecting refresh mode one.
// R12: Address strobe marks start and duration of each bus cycle.
// R13: Hidden refresh occurs with refresh clock high, no select, address strobe low.
// R14: Refresh clock fall without hidden refresh raises request, forcing refresh.
// R15: Access during forced refresh waits until refresh and precharge end.
// R16: Read cycles start row strobe at once; select must be early enough.
// R17: Delay stages, mode output and row strobe are clocked registers.
module cdg_seq (
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Processor bus.
  input wire logic CPU_ADDR_STROBE_N,
  input wire logic CHIP_SELECT_N,
  input wire logic READ_N_WRITE,
  input wire logic BYTE_STROBE_ANY_N,
  input wire logic WAIT_REQ_N,
  // Configuration and refresh timing.
  input wire logic HIDDEN_REFRESH_ALLOW,
  input wire logic REFRESH_CLOCK_IN,
  input wire logic OUTPUT_ENABLE_N,
  // Controller side.
  output logic ROW_STROBE_REQUEST_N,
  output logic CTRL_MODE_SELECT_BIT,
  output logic CYCLE_DONE_N,
  output logic ACCESS_PENDING_IN_REFRESH_N,
  output logic TRANSFER_ACK_N,
  output logic OUTPUTS_DRIVEN
);
  cdg_pkg::cdg_bus_in_t bus;
  cdg_pkg::cdg_state_t state_reg;
  logic delay_stage_a;
  logic delay_stage_b;
  logic refresh_request;
  logic refresh_clock_prev;
  logic refresh_clock_armed;
  logic hidden_done;
  logic wait_used;
  logic [3:0] count_reg;
  logic in_cycle;
  logic selected;
  logic hidden_ok;

  cdg_sync u_as (.clk(CORE_CLK), .rst_n(RST_N), .pin(CPU_ADDR_STROBE_N), .level(bus.addr_strobe_n));
  cdg_sync u_cs (.clk(CORE_CLK), .rst_n(RST_N), .pin(CHIP_SELECT_N), .level(bus.chip_select_n));
  cdg_sync u_bs (.clk(CORE_CLK), .rst_n(RST_N), .pin(BYTE_STROBE_ANY_N), .level(bus.byte_strobe_any_n));
  cdg_sync u_wt (.clk(CORE_CLK), .rst_n(RST_N), .pin(WAIT_REQ_N), .level(bus.wait_req_n));
  cdg_sync u_dh (.clk(CORE_CLK), .rst_n(RST_N), .pin(HIDDEN_REFRESH_ALLOW), .level(bus.hidden_refresh_allow));
  cdg_sync u_rf (.clk(CORE_CLK), .rst_n(RST_N), .pin(REFRESH_CLOCK_IN), .level(bus.refresh_clock_in));
  cdg_sync u_rw (.clk(CORE_CLK), .rst_n(RST_N), .pin(READ_N_WRITE), .level(bus.read_n_write));

  assign in_cycle = !bus.addr_strobe_n; // R12
  assign selected = in_cycle && !bus.chip_select_n;
  // R3 R13
  assign hidden_ok = in_cycle && bus.chip_select_n && bus.hidden_refresh_allow && bus.refresh_clock_in
                     && !hidden_done;

  // The sequencer feeds stage a, which follows the start state one cycle later; stage b trails stage a by one cycle.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= cdg_pkg::CDG_IDLE;
      count_reg <= 4'h0;
      wait_used <= 1'b0;
    end else begin
      case (state_reg)
        cdg_pkg::CDG_IDLE: begin
          wait_used <= 1'b0;
          if (refresh_request && !selected) begin
            state_reg <= cdg_pkg::CDG_FORCE; // R14
            count_reg <= cdg_pkg::FORCE_CYCLES;
          end else if (selected || hidden_ok) begin
            state_reg <= cdg_pkg::CDG_START; // R7
          end
        end
        cdg_pkg::CDG_START: begin
          if (selected && !bus.wait_req_n && !wait_used) begin
            wait_used <= 1'b1; // R1
          end else begin
            state_reg <= cdg_pkg::CDG_RUN;
          end
        end
        cdg_pkg::CDG_RUN: begin
          state_reg <= cdg_pkg::CDG_DONE;
        end
        cdg_pkg::CDG_DONE: begin
          if (!in_cycle) begin
            state_reg <= cdg_pkg::CDG_IDLE; // R6
          end
        end
        cdg_pkg::CDG_FORCE: begin
          if (count_reg <= 4'h1) begin
            state_reg <= cdg_pkg::CDG_PRECH;
            count_reg <= cdg_pkg::PRECH_CYCLES;
          end else begin
            count_reg <= count_reg - 4'h1;
          end
        end
        cdg_pkg::CDG_PRECH: begin
          if (count_reg <= 4'h1) begin
            state_reg <= cdg_pkg::CDG_IDLE; // R15
          end else begin
            count_reg <= count_reg - 4'h1;
          end
        end
        default: begin
          state_reg <= cdg_pkg::CDG_IDLE;
        end
      endcase
    end
  end

  // R17
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      delay_stage_a <= 1'b0;
      delay_stage_b <= 1'b0;
    end else begin
      delay_stage_a <= (state_reg == cdg_pkg::CDG_START);
      delay_stage_b <= delay_stage_a;
    end
  end

  // Refresh request: set on the falling refresh clock unless a hidden refresh already ran.
  // The synchronisers leave reset reading high, so a fall counts only after a real rise was seen.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      refresh_clock_prev <= 1'b1;
      refresh_clock_armed <= 1'b0;
      hidden_done <= 1'b0;
      refresh_request <= 1'b0;
    end else begin
      refresh_clock_prev <= bus.refresh_clock_in;
      if (!refresh_clock_prev && bus.refresh_clock_in) begin
        refresh_clock_armed <= 1'b1;
      end
      if (refresh_clock_armed && refresh_clock_prev && !bus.refresh_clock_in) begin
        refresh_request <= !hidden_done; // R14
        hidden_done <= 1'b0;
      end else begin
        if (state_reg == cdg_pkg::CDG_IDLE && hidden_ok && !refresh_request) begin
          hidden_done <= 1'b1; // R13
        end
        if (state_reg == cdg_pkg::CDG_FORCE) begin
          refresh_request <= 1'b0;
        end
      end
    end
  end

  // Row strobe is registered and held from start to done; a forced refresh also drives it.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ROW_STROBE_REQUEST_N <= 1'b1;
      CTRL_MODE_SELECT_BIT <= 1'b1;
    end else begin
      // R7 R16 R10 R17
      ROW_STROBE_REQUEST_N <= !((state_reg == cdg_pkg::CDG_IDLE && (selected || hidden_ok) && !refresh_request)
                               || state_reg == cdg_pkg::CDG_START || state_reg == cdg_pkg::CDG_RUN
                               || (state_reg == cdg_pkg::CDG_DONE && in_cycle)
                               || state_reg == cdg_pkg::CDG_FORCE);
      CTRL_MODE_SELECT_BIT <= !(state_reg == cdg_pkg::CDG_FORCE || // R11
                                (state_reg == cdg_pkg::CDG_IDLE && refresh_request && !selected));
    end
  end

  // Done, pending and acknowledge outputs.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CYCLE_DONE_N <= 1'b1;
      ACCESS_PENDING_IN_REFRESH_N <= 1'b1;
      TRANSFER_ACK_N <= 1'b1;
      OUTPUTS_DRIVEN <= 1'b0;
    end else begin
      OUTPUTS_DRIVEN <= !OUTPUT_ENABLE_N; // R4
      if (!in_cycle) begin
        CYCLE_DONE_N <= 1'b1; // R6
      end else if (state_reg == cdg_pkg::CDG_DONE && !delay_stage_a && !delay_stage_b) begin
        CYCLE_DONE_N <= 1'b0; // R5
      end
      // R9 R15
      ACCESS_PENDING_IN_REFRESH_N <= !(selected && (state_reg == cdg_pkg::CDG_FORCE
                                                    || state_reg == cdg_pkg::CDG_PRECH));
      // R8 R2
      TRANSFER_ACK_N <= !(selected && !bus.byte_strobe_any_n &&
                          (state_reg == cdg_pkg::CDG_RUN || state_reg == cdg_pkg::CDG_DONE));
    end
  end

  a_ack_needs_select: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R8
    !TRANSFER_ACK_N |-> $past(selected)) else $error("ack without selected access");
  a_pending_blocks_ack: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R9
    !ACCESS_PENDING_IN_REFRESH_N |-> TRANSFER_ACK_N) else $error("ack during refresh");
  a_mode_in_force: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R11
    state_reg == cdg_pkg::CDG_FORCE |=> !CTRL_MODE_SELECT_BIT) else $error("mode not low in refresh");
  a_done_clears: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R6
    !in_cycle |=> CYCLE_DONE_N) else $error("done not released");
  a_done_stages: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R5
    $fell(CYCLE_DONE_N) |-> !$past(delay_stage_a) && !$past(delay_stage_b)) else $error("done early");
  a_wait_once: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R1
    state_reg == cdg_pkg::CDG_START && wait_used |=> state_reg != cdg_pkg::CDG_START)
    else $error("more than one wait");
  a_force_length: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R15
    $rose(state_reg == cdg_pkg::CDG_FORCE) |-> (state_reg == cdg_pkg::CDG_FORCE) [*4] ##1
    state_reg == cdg_pkg::CDG_PRECH) else $error("forced refresh length");
  a_row_start: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R7
    state_reg == cdg_pkg::CDG_START |-> !ROW_STROBE_REQUEST_N) else $error("row strobe missing");
  a_stage_chain: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R17
    delay_stage_a |=> delay_stage_b) else $error("delay chain broken");
  a_refresh_no_start: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R10
    (state_reg == cdg_pkg::CDG_FORCE || state_reg == cdg_pkg::CDG_PRECH) |=> state_reg != cdg_pkg::CDG_START)
    else $error("cycle started during refresh");

  c_access: cover property (@(posedge CORE_CLK) disable iff (!RST_N) $fell(TRANSFER_ACK_N));
  c_force: cover property (@(posedge CORE_CLK) disable iff (!RST_N) $fell(CTRL_MODE_SELECT_BIT));
  c_pending: cover property (@(posedge CORE_CLK) disable iff (!RST_N) $fell(ACCESS_PENDING_IN_REFRESH_N));
  c_hidden: cover property (@(posedge CORE_CLK) disable iff (!RST_N) $rose(hidden_done));
endmodule

// ===== hdl/cdg_pkg.sv
package cdg_pkg;

  // Bus-side inputs after synchronisation.
  typedef struct packed {
    logic addr_strobe_n;
    logic chip_select_n;
    logic byte_strobe_any_n;
    logic wait_req_n;
    logic hidden_refresh_allow;
    logic refresh_clock_in;
    logic read_n_write;
  } cdg_bus_in_t;

  // Sequencer states, Gray coded along idle, start, run, done.
  typedef enum logic [2:0] {
    CDG_IDLE = 3'b000,
    CDG_START = 3'b001,
    CDG_RUN = 3'b011,
    CDG_DONE = 3'b010,
    CDG_FORCE = 3'b110,
    CDG_PRECH = 3'b111
  } cdg_state_t;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned FORCE_TIME_NS = 40;
  localparam int unsigned PRECH_TIME_NS = 20;
  localparam logic [3:0] FORCE_CYCLES =
    4'((FORCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] PRECH_CYCLES =
    4'((PRECH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] SYNC_RESET = 3'h7;
  localparam logic RST_HIGH = 1'b1;

endpackage

// ===== hdl/cdg_sync.sv
`timescale 1ns/1ps
module cdg_sync (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Raw pin and filtered level.
  input wire logic pin,
  output logic level
);
  logic [2:0] pipe_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pipe_reg <= cdg_pkg::SYNC_RESET;
    end else begin
      pipe_reg <= {pipe_reg[1:0], pin};
    end
  end

  // A change is accepted only when the second and third stages agree.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= cdg_pkg::RST_HIGH;
    end else if (pipe_reg[1] == pipe_reg[2]) begin
      level <= pipe_reg[2];
    end
  end
endmodule

// ===== sim/cdg_cpu_model.sv
`timescale 1ns/1ps
module cdg_cpu_model (
  // Clock and device answers.
  input wire logic clk,
  input wire logic ack_n,
  input wire logic row_n,
  input wire logic pend_n,
  input wire logic done_n,
  // Bus strobes.
  output logic as_n,
  output logic cs_n,
  output logic bs_n,
  output logic rnw,
  // Result of the last cycle.
  output logic res_stb,
  output logic [7:0] res_lat,
  output logic [2:0] res_flags
);
  initial begin
    as_n = 1'b1;
    cs_n = 1'b1;
    bs_n = 1'b1;
    rnw = 1'b1;
    res_stb = 1'b0;
    res_lat = 8'h00;
    res_flags = 3'h0;
  end
  // Unselected cycles end after a fixed time, as another slave would answer them.
  task run(input logic sel, input logic rd);
    int n;
    logic row, pend, done;
    begin
      n = 0;
      row = 1'b0;
      pend = 1'b0;
      @(negedge clk);
      cs_n = ~sel;
      rnw = rd;
      as_n = 1'b0;
      bs_n = 1'b0;
      while (n < 40 && (sel ? ack_n !== 1'b0 : n < 10)) begin
        @(negedge clk);
        n++;
        row |= (row_n === 1'b0);
        pend |= (pend_n === 1'b0);
      end
      res_lat = 8'(n);
      repeat (2) @(negedge clk);
      done = (done_n === 1'b0);
      as_n = 1'b1;
      cs_n = 1'b1;
      bs_n = 1'b1;
      rnw = ~rd;
      repeat (6) @(negedge clk);
      res_flags = {row, pend, done && done_n === 1'b1 && row_n === 1'b1 && ack_n === 1'b1};
      res_stb = 1'b1;
      @(negedge clk);
      res_stb = 1'b0;
    end
  endtask
endmodule

// ===== sim/tb.sv
`timescale 1ns/1ps
module tb;
  typedef struct {logic [7:0] lo; logic [7:0] hi; logic [2:0] fl; logic [2:0] mk;} cdg_tb_exp_t;
  logic CORE_CLK = 1'b0, RST_N = 1'b0, WAIT_REQ_N = 1'b1, HIDDEN_REFRESH_ALLOW = 1'b1;
  logic REFRESH_CLOCK_IN = 1'b0, OUTPUT_ENABLE_N = 1'b1;
  logic as_n, cs_n, bs_n, rnw, row_n, mode, done_n, pend_n, ack_n, drv, res_stb;
  logic [7:0] res_lat;
  logic [2:0] res_flags;
  logic [31:0] w;
  cdg_tb_exp_t exp_q[$];
  int failures = 0, samples_checked = 0, cycles = 0, seed = 36, i;
  always #5 CORE_CLK = ~CORE_CLK;
  cdg_seq dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CPU_ADDR_STROBE_N(as_n), .CHIP_SELECT_N(cs_n),
    .READ_N_WRITE(rnw), .BYTE_STROBE_ANY_N(bs_n), .WAIT_REQ_N(WAIT_REQ_N),
    .HIDDEN_REFRESH_ALLOW(HIDDEN_REFRESH_ALLOW), .REFRESH_CLOCK_IN(REFRESH_CLOCK_IN),
    .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .ROW_STROBE_REQUEST_N(row_n), .CTRL_MODE_SELECT_BIT(mode),
    .CYCLE_DONE_N(done_n), .ACCESS_PENDING_IN_REFRESH_N(pend_n), .TRANSFER_ACK_N(ack_n),
    .OUTPUTS_DRIVEN(drv));
  cdg_cpu_model u_cpu (.clk(CORE_CLK), .ack_n(ack_n), .row_n(row_n), .pend_n(pend_n), .done_n(done_n),
    .as_n(as_n), .cs_n(cs_n), .bs_n(bs_n), .rnw(rnw), .res_stb(res_stb), .res_lat(res_lat),
    .res_flags(res_flags));
  task chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      failures++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task bus(input logic sel, input logic rd, input logic [7:0] lo, input logic [7:0] hi, input logic [2:0] fl);
    exp_q.push_back('{lo, hi, fl, sel ? 3'h7 : 3'h6});
    u_cpu.run(sel, rd);
  endtask
  // Flags are row strobe seen, pending seen, done low then released.
  always @(posedge res_stb) begin
    cdg_tb_exp_t e;
    if (exp_q.size() == 0) begin
      chk(1'b0, "result with no expectation");
    end else begin
      e = exp_q.pop_front();
      chk((res_flags & e.mk) === (e.fl & e.mk) && res_lat >= e.lo && res_lat <= e.hi, "bus cycle");
    end
  end
  // Polls for a forced refresh, which lasts only a few cycles.
  task mode_low(input logic want);
    logic seen;
    seen = 1'b0;
    repeat (16) begin
      @(negedge CORE_CLK);
      seen |= (mode === 1'b0);
    end
    chk(seen === want, "forced refresh mode");
  endtask
  task complete_run;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    repeat (4) @(negedge CORE_CLK);
    chk({row_n, ack_n, done_n, pend_n, mode, drv} === 6'b111110, "reset values");
    RST_N = 1'b1;
    OUTPUT_ENABLE_N = 1'b0;
    repeat (6) @(negedge CORE_CLK);
    chk(drv === 1'b1, "outputs not driven");
    bus(1'b1, 1'b1, 8'h06, 8'h07, 3'b101);
    WAIT_REQ_N = 1'b0;
    bus(1'b1, 1'b0, 8'h07, 8'h08, 3'b101);
    WAIT_REQ_N = 1'b1;
    REFRESH_CLOCK_IN = 1'b1;
    bus(1'b0, 1'b1, 8'h00, 8'h0a, 3'b100);
    REFRESH_CLOCK_IN = 1'b0;
    mode_low(1'b0);
    HIDDEN_REFRESH_ALLOW = 1'b0;
    REFRESH_CLOCK_IN = 1'b1;
    bus(1'b0, 1'b1, 8'h00, 8'h0a, 3'b000);
    REFRESH_CLOCK_IN = 1'b0;
    mode_low(1'b1);
    HIDDEN_REFRESH_ALLOW = 1'b1;
    REFRESH_CLOCK_IN = 1'b1;
    repeat (4) @(negedge CORE_CLK);
    REFRESH_CLOCK_IN = 1'b0;
    @(negedge CORE_CLK);
    bus(1'b1, 1'b1, 8'h08, 8'h18, 3'b111);
    for (i = 0; i < 6; i++) begin
      w = $random(seed);
      WAIT_REQ_N = w[0];
      bus(1'b1, w[1], w[0] ? 8'h06 : 8'h07, w[0] ? 8'h07 : 8'h08, 3'b101);
    end
    complete_run();
  end
endmodule
